// file: design/osd_pkg.sv
// shared constants and types for the overlay output and origin block
package osd_pkg;
  // ==========================================
  // origin register
  localparam logic [3:0] ORIGIN_ADDR  = 4'h1;
  localparam logic [7:0] ORIGIN_RESET = 8'h00;
  localparam int         FIELD_W      = 4;
  localparam int         ORG_H_LSB    = 0;
  localparam int         ORG_V_LSB    = 4;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int HSTART_NS     = 4250;
  localparam int DOT_NS        = 250;
  // least times, so round up
  localparam int HSTART_CYC    = (HSTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DOT_CYC       = (DOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VSTART_LINES  = 17;
  localparam int LINE_W        = 9;
  localparam int DOTS_PER_CHAR = 10;
  localparam int CHAR_COLS     = 19;
  localparam int SCREEN_ROWS   = 12;
  localparam int ROW_WORDS     = 15;
  localparam int AREA_LINES    = ROW_WORDS * SCREEN_ROWS;
  // ==========================================
  // pattern rom layout
  localparam logic [3:0] CTRL_SLOT    = 4'hf;
  localparam int         TRIM_SEL_BIT = 15;
  localparam int         PLAIN_MSB    = 9;
  localparam int         TRIM_PAT_MSB = 14;
  localparam int         TRIM_MSB     = 9;
  localparam int         HSIZE_LSB    = 13;
  localparam int         VSIZE_LSB    = 11;
  localparam int         HPOS_LSB     = 7;
  localparam int         VPOS_LSB     = 3;
  localparam int         COLOUR_LSB   = 0;
  localparam int         COLOUR_W     = 3;
  localparam int         RED_BIT      = 2;
  localparam int         GREEN_BIT    = 1;
  localparam int         BLUE_BIT     = 0;
  // carriage return: nibble 0100 then 0000
  localparam logic [7:0] CR_CODE      = 8'h40;

  typedef enum {h_idle, h_wait, h_draw} h_state_type;
endpackage : osd_pkg

// file: design/dot_link_if.sv
// link between the line timer and the dot serialiser
`timescale 1ns/1ps
interface dot_link_if;
  logic        load;
  logic [15:0] row;
  logic [2:0]  colour;
  logic        char_end;
  logic [2:0]  pix_rgb;
  logic        pix_trim;
  modport src  (output load, row, colour, input char_end, pix_rgb, pix_trim);
  modport sink (input load, row, colour, output char_end, pix_rgb, pix_trim);
endinterface : dot_link_if

// file: design/sync_edge.sv
// trailing edge finder for an active-low sync input
`timescale 1ns/1ps
module sync_edge (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_sync_n,
  output logic      o_trail
);
  logic prev;
  logic next_prev;

  always_comb begin
    next_prev = i_sync_n;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      prev <= 1'b1;
    end else begin
      prev <= next_prev;
    end
  end

  // trailing edge of a low pulse is the rise
  assign o_trail = i_sync_n & ~prev;
endmodule : sync_edge

// file: design/dot_serializer.sv
// turns one pattern row word into a run of ten coloured dots
`timescale 1ns/1ps
module dot_serializer (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  dot_link_if.sink link
);
  import osd_pkg::*;
  localparam int char_cycles = DOTS_PER_CHAR * DOT_CYC;

  logic [15:0] row, next_row;
  logic [2:0]  colour, next_colour;
  logic [3:0]  dot, next_dot;
  logic [1:0]  phase, next_phase;
  logic        busy, next_busy;
  logic        trimmed, dot_on, trim_on;

  // ==========================================
  // dot stepping
  always_comb begin
    next_row    = row;
    next_colour = colour;
    next_dot    = dot;
    next_phase  = phase;
    next_busy   = busy;
    if (link.load) begin
      next_row    = link.row;
      next_colour = link.colour;
      next_dot    = 4'h0;
      next_phase  = 2'h0;
      next_busy   = 1'b1;
    end else if (busy) begin
      if (phase == 2'(DOT_CYC - 1)) begin
        next_phase = 2'h0;
        if (dot == 4'(DOTS_PER_CHAR - 1)) begin
          next_busy = 1'b0;
        end else begin
          next_dot = dot + 4'h1;
        end
      end else begin
        next_phase = phase + 2'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      row    <= 16'h0000;
      colour <= 3'h0;
      dot    <= 4'h0;
      phase  <= 2'h0;
      busy   <= 1'b0;
    end else begin
      row    <= next_row;
      colour <= next_colour;
      dot    <= next_dot;
      phase  <= next_phase;
      busy   <= next_busy;
    end
  end

  // ==========================================
  // pixel decode
  assign trimmed = row[TRIM_SEL_BIT];
  // trimmed rows carry 5 pattern bits, each shown as two dots
  assign dot_on  = trimmed ? row[4'(TRIM_PAT_MSB) - (dot >> 1)]
                           : row[4'(PLAIN_MSB) - dot];
  assign trim_on = trimmed & row[4'(TRIM_MSB) - dot];
  assign link.pix_rgb  = (busy & dot_on) ? colour : 3'h0;
  assign link.pix_trim = busy & trim_on;
  assign link.char_end = busy & (phase == 2'(DOT_CYC - 1))
                       & (dot == 4'(DOTS_PER_CHAR - 1));

  // ==========================================
  // checks
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  logic [7:0] since_load;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      since_load <= 8'h00;
    end else begin
      since_load <= link.load ? 8'h00 : since_load + 8'h01;
    end
  end

  chk_char_dot_time: assert property (
    link.char_end |-> since_load == 8'(char_cycles - 1))
    else $error("character did not last ten dot steps");
  chk_plain_first_dot: assert property (
    link.load && !link.row[TRIM_SEL_BIT] && link.row[PLAIN_MSB]
    |=> link.pix_rgb == $past(link.colour) && !link.pix_trim)
    else $error("plain first dot colour wrong");
  chk_trim_outline: assert property (
    link.load && link.row[TRIM_SEL_BIT] && link.row[TRIM_MSB]
    |=> link.pix_trim [*2])
    else $error("trimming dot missing");
  cov_trim_load: cover property (link.load && link.row[TRIM_SEL_BIT]);
endmodule : dot_serializer

// file: design/osd_output_and_origin.sv
// overlay origin timing, origin register and rgb / blanking outputs
`timescale 1ns/1ps
// Functional notes
// - red, green, blue, blanking are push-pull outputs, high when active
// - blanking asserts wherever the broadcast picture is replaced by overlay
// - untrimmed: blanking equals OR of red, green, blue, dot for dot
// - trimmed: blanking forms an outline around the dots from trim bits
// - 8-bit origin register, vertical and horizontal nibbles, port address 01
// - sixteen origin settings each way move the whole overlay
// - horizontal start 4.25 us after hsync trailing edge plus 250 ns per unit; rounded up to 43 and 3 cycles of 100 ns, so 4.3 us plus 300 ns per unit
// - vertical start 17 lines after vsync trailing edge plus one per unit
// - first hsync after vsync rise is counted as line one
// - carriage return code is nibbles 0100 then 0000 ending a line
// - colour bit 2 drives red, bit 1 green, bit 0 blue
// - pattern rows at offsets 0 to e, control word at offset f
// - row msb selects plain ten-dot or trimmed five-bit doubled rows
// - control word field positions: sizes, positions, colour in bits 2-0; only the colour field is decoded
module osd_output_and_origin (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_hsync_n,
  input  wire logic        i_vsync_n,
  input  wire logic        i_display_enable_flag,
  input  wire logic [3:0]  i_periph_addr,
  input  wire logic [7:0]  i_periph_wdata,
  input  wire logic        i_periph_write,
  input  wire logic        i_periph_read,
  output logic      [7:0]  o_periph_rdata,
  input  wire logic [7:0]  i_char_code,
  input  wire logic [15:0] i_rom_row_data,
  input  wire logic [15:0] i_rom_ctrl_data,
  output logic      [4:0]  o_char_col,
  output logic      [3:0]  o_char_row,
  output logic      [11:0] o_rom_row_addr,
  output logic      [11:0] o_rom_ctrl_addr,
  output logic             o_red,
  output logic             o_green,
  output logic             o_blue,
  output logic             o_blank,
  output logic             o_vsync_low_flag
);
  import osd_pkg::*;

  dot_link_if link ();

  logic                 hs_trail, vs_trail;
  logic [7:0]           origin, next_origin;
  logic [7:0]           next_rdata;
  logic [LINE_W-1:0]    line, next_line;
  logic                 in_area, next_in_area;
  logic [3:0]           row_line, next_row_line;
  logic [3:0]           next_char_row;
  logic [4:0]           next_char_col;
  h_state_type          h_state, next_h_state;
  logic [7:0]           h_cnt, next_h_cnt;
  logic [7:0]           start_cyc;
  logic [LINE_W-1:0]    vstart;
  logic                 en;
  logic                 next_red, next_green, next_blue, next_blank;

  // ==========================================
  // sync edges and dot serialiser
  sync_edge hs_edge (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_sync_n  (i_hsync_n),
    .o_trail   (hs_trail)
  );

  sync_edge vs_edge (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_sync_n  (i_vsync_n),
    .o_trail   (vs_trail)
  );

  dot_serializer serial (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .link      (link.sink)
  );

  assign en = i_display_enable_flag;

  // whole-screen shift from the two origin nibbles
  assign start_cyc = 8'(HSTART_CYC)
                   + origin[ORG_H_LSB +: FIELD_W] * 8'(DOT_CYC);
  assign vstart    = LINE_W'(VSTART_LINES)
                   + LINE_W'(origin[ORG_V_LSB +: FIELD_W]);

  // ==========================================
  // origin register on the peripheral port
  always_comb begin
    next_origin = origin;
    next_rdata  = o_periph_rdata;
    // write is taken whenever strobed; software keeps display off meanwhile
    if (i_periph_write && i_periph_addr == ORIGIN_ADDR) begin
      next_origin = i_periph_wdata;
    end
    if (i_periph_read) begin
      next_rdata = (i_periph_addr == ORIGIN_ADDR) ? origin : 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      origin         <= ORIGIN_RESET;
      o_periph_rdata <= 8'h00;
    end else begin
      origin         <= next_origin;
      o_periph_rdata <= next_rdata;
    end
  end

  // ==========================================
  // vertical line counting
  always_comb begin
    next_line     = line;
    next_in_area  = in_area;
    next_row_line = row_line;
    next_char_row = o_char_row;
    if (vs_trail) begin
      next_line    = '0;
      next_in_area = 1'b0;
    end else if (hs_trail) begin
      // first hsync after the vsync rise becomes line one
      next_line = (line == '1) ? line : line + 1'b1;
      if (next_line == vstart) begin
        next_in_area  = 1'b1;
        next_row_line = 4'h0;
        next_char_row = 4'h0;
      end else if (in_area) begin
        if (next_line == vstart + LINE_W'(AREA_LINES)) begin
          next_in_area = 1'b0;
        end else if (row_line == 4'(ROW_WORDS - 1)) begin
          next_row_line = 4'h0;
          next_char_row = o_char_row + 4'h1;
        end else begin
          next_row_line = row_line + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      line       <= '0;
      in_area    <= 1'b0;
      row_line   <= 4'h0;
      o_char_row <= 4'h0;
    end else begin
      line       <= next_line;
      in_area    <= next_in_area;
      row_line   <= next_row_line;
      o_char_row <= next_char_row;
    end
  end

  // ==========================================
  // horizontal start and character loading
  always_comb begin
    next_h_state  = h_state;
    next_h_cnt    = h_cnt;
    next_char_col = o_char_col;
    link.load     = 1'b0;
    link.row      = i_rom_row_data;
    link.colour   = i_rom_ctrl_data[COLOUR_LSB +: COLOUR_W];
    if (!en) begin
      next_h_state = h_idle;
    end else if (hs_trail) begin
      next_h_state  = next_in_area ? h_wait : h_idle;
      next_h_cnt    = 8'h00;
      next_char_col = 5'h00;
    end else begin
      case (h_state)
        h_wait: begin
          if (h_cnt == start_cyc - 8'h01) begin
            next_h_state = h_draw;
          end else begin
            next_h_cnt = h_cnt + 8'h01;
          end
        end
        h_draw: begin
        end
        default: begin
        end
      endcase
      if ((h_state == h_wait && h_cnt == start_cyc - 8'h01)
          || (h_state == h_draw && link.char_end)) begin
        // a carriage return or the last column ends the line
        if (o_char_col == 5'(CHAR_COLS) || i_char_code == CR_CODE) begin
          next_h_state = h_idle;
        end else begin
          link.load     = 1'b1;
          next_char_col = o_char_col + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      h_state    <= h_idle;
      h_cnt      <= 8'h00;
      o_char_col <= 5'h00;
    end else begin
      h_state    <= next_h_state;
      h_cnt      <= next_h_cnt;
      o_char_col <= next_char_col;
    end
  end

  // ==========================================
  // rom addressing and pin outputs
  always_comb begin
    // dots come out as push-pull high-active levels
    next_red   = en & link.pix_rgb[RED_BIT];
    next_green = en & link.pix_rgb[GREEN_BIT];
    next_blue  = en & link.pix_rgb[BLUE_BIT];
    // blanking is the colour OR, widened by trimming dots
    next_blank = en & ((|link.pix_rgb) | link.pix_trim);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_red            <= 1'b0;
      o_green          <= 1'b0;
      o_blue           <= 1'b0;
      o_blank          <= 1'b0;
      o_vsync_low_flag <= 1'b0;
      o_rom_row_addr   <= 12'h000;
      o_rom_ctrl_addr  <= 12'h000;
    end else begin
      o_red            <= next_red;
      o_green          <= next_green;
      o_blue           <= next_blue;
      o_blank          <= next_blank;
      o_vsync_low_flag <= ~i_vsync_n;
      o_rom_row_addr   <= {i_char_code, row_line};
      o_rom_ctrl_addr  <= {i_char_code, CTRL_SLOT};
    end
  end

  // ==========================================
  // checks
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  logic [7:0] since_hs;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      since_hs <= 8'h00;
    end else if (hs_trail) begin
      since_hs <= 8'h01;
    end else if (since_hs != 8'hff) begin
      since_hs <= since_hs + 8'h01;
    end
  end

  chk_off_outputs_low: assert property (
    !en |=> !o_red && !o_green && !o_blue && !o_blank)
    else $error("outputs active while display disabled");
  chk_blank_covers_rgb: assert property (
    (o_red || o_green || o_blue) |-> o_blank)
    else $error("coloured dot without blanking");
  chk_blank_plain_or: assert property (
    !link.pix_trim |=> o_blank == (o_red | o_green | o_blue))
    else $error("plain blanking differs from colour OR");
  chk_origin_write: assert property (
    i_periph_write && i_periph_addr == ORIGIN_ADDR
    |=> origin == $past(i_periph_wdata))
    else $error("origin write lost");
  chk_origin_read: assert property (
    i_periph_read && !i_periph_write && i_periph_addr == ORIGIN_ADDR
    |=> o_periph_rdata == origin)
    else $error("origin readback wrong");
  chk_hstart_delay: assert property (
    h_state == h_wait && link.load |-> since_hs == start_cyc)
    else $error("horizontal start at wrong cycle");
  chk_vstart_line: assert property (
    $rose(in_area) |-> line == vstart)
    else $error("vertical start on wrong line");
  // pending from a vsync rise until the first hsync after it
  logic first_pend;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      first_pend <= 1'b0;
    end else if (vs_trail) begin
      first_pend <= 1'b1;
    end else if (hs_trail) begin
      first_pend <= 1'b0;
    end
  end

  chk_area_first_count: assert property (
    hs_trail && first_pend && !vs_trail |=> line == LINE_W'(1))
    else $error("first hsync not counted as one");
  cov_line_start: cover property (h_state == h_wait ##1 h_state == h_draw);
  cov_cr_end: cover property (h_state == h_draw ##1 h_state == h_idle);
  cov_area_enter: cover property ($rose(in_area));
endmodule : osd_output_and_origin

// file: test/tv_side_model.sv
// television side: sync timing, character memory and pattern rom answers
`timescale 1ns/1ps
module tv_side_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic        i_mode,
  input  wire logic [4:0]  i_char_col,
  input  wire logic [11:0] i_row_addr,
  input  wire logic [11:0] i_ctrl_addr,
  output logic             o_hsync_n,
  output logic             o_vsync_n,
  output logic      [7:0]  o_char_code,
  output logic      [15:0] o_row_data,
  output logic      [15:0] o_ctrl_data,
  output logic      [9:0]  o_hpos,
  output logic      [5:0]  o_line
);
  // ==========================================
  // sync timing: 700 cycles a line, 24 lines a frame
  logic [4:0] lcount;
  assign o_hsync_n = (o_hpos >= 10'h032);
  // vsync rises mid-line so it never meets an hsync edge
  assign o_vsync_n = !((lcount == 5'h00) || (lcount == 5'h01 && o_hpos < 10'h12c));
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_hpos <= 10'h000;
      lcount <= 5'h00;
      o_line <= 6'h00;
    end else begin
      o_hpos <= (o_hpos == 10'h2bb) ? 10'h000 : o_hpos + 10'h001;
      if (o_hpos == 10'h2bb) begin
        lcount <= (lcount == 5'h17) ? 5'h00 : lcount + 5'h01;
      end
      if (lcount == 5'h01 && o_hpos == 10'h12b) begin
        o_line <= 6'h00;
      end else if (o_hpos == 10'h031) begin
        o_line <= o_line + 6'h01;
      end
    end
  end
  // ==========================================
  // character memory and pattern rom
  always_comb begin
    o_char_code = {3'h0, i_char_col} + 8'h01;
    if (i_mode && i_char_col == 5'h00) begin
      o_char_code = 8'h81;
    end else if (i_mode && i_char_col == 5'h04) begin
      o_char_code = 8'h40;
    end
  end
  // rom answers one cycle late, inside the two-cycle allowance
  always_ff @(posedge i_ref_clk) begin
    // trimmed row also trims its first lit dot, so the outline check has work
    o_row_data  <= i_row_addr[11] ? 16'hc2c0 : 16'h03ff;
    o_ctrl_data <= {13'h0000, i_ctrl_addr[6:4]};
  end
endmodule : tv_side_model

// file: test/tb_osd_output_and_origin.sv
// self-checking bench for the overlay output and origin block
`timescale 1ns/1ps
module tb_osd_output_and_origin;
  import osd_pkg::*;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        hsync_n, vsync_n, enable, write, read, mode;
  logic        red, green, blue, blank, vlow;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, char_code;
  logic [15:0] row_data, ctrl_data;
  logic [4:0]  char_col;
  logic [3:0]  char_row;
  logic [11:0] row_addr, ctrl_addr;
  logic [9:0]  hpos;
  logic [5:0]  line;
  logic [2:0]  rgbs [0:699];
  int          bad_count = 0;
  int          num_checks = 0;
  int          pre_n, blank_n, rgb_n, diff_n, first_h, a_h, row_info;

  always #50 ref_clk = ~ref_clk;

  osd_output_and_origin uut (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_hsync_n(hsync_n), .i_vsync_n(vsync_n),
    .i_display_enable_flag(enable), .i_periph_addr(addr), .i_periph_wdata(wdata),
    .i_periph_write(write), .i_periph_read(read), .o_periph_rdata(rdata),
    .i_char_code(char_code), .i_rom_row_data(row_data), .i_rom_ctrl_data(ctrl_data),
    .o_char_col(char_col), .o_char_row(char_row), .o_rom_row_addr(row_addr),
    .o_rom_ctrl_addr(ctrl_addr), .o_red(red), .o_green(green), .o_blue(blue),
    .o_blank(blank), .o_vsync_low_flag(vlow));

  tv_side_model tv (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_mode(mode), .i_char_col(char_col),
    .i_row_addr(row_addr), .i_ctrl_addr(ctrl_addr), .o_hsync_n(hsync_n),
    .o_vsync_n(vsync_n), .o_char_code(char_code), .o_row_data(row_data),
    .o_ctrl_data(ctrl_data), .o_hpos(hpos), .o_line(line));

  // ==========================================
  // shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge ref_clk);
    write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    addr <= a;
    read <= 1'b1;
    @(posedge ref_clk);
    read <= 1'b0;
    @(negedge ref_clk);
    check({8'h00, rdata}, {8'h00, exp});
  endtask : rd

  // one whole frame; counts overlay activity before and on the first area line
  task automatic frame(input logic [3:0] v, input logic [3:0] h, input logic on,
                       input logic m);
    int waited;
    int exp_line;
    waited = 0;
    exp_line = VSTART_LINES + int'(v);
    pre_n = 0;
    blank_n = 0;
    rgb_n = 0;
    diff_n = 0;
    first_h = -1;
    row_info = -1;
    @(posedge ref_clk);
    enable <= 1'b0;
    mode <= m;
    wr(ORIGIN_ADDR, {v, h});
    rd(ORIGIN_ADDR, {v, h});
    while (vlow !== 1'b1 && waited < 20000) begin
      @(posedge ref_clk);
      waited++;
    end
    if (waited >= 20000) begin
      bad_count++;
    end
    enable <= on;
    while (vsync_n !== 1'b1) @(negedge ref_clk);
    while (vsync_n !== 1'b0) begin
      @(negedge ref_clk);
      if (int'(line) < exp_line) begin
        pre_n += int'(blank | red | green | blue);
      end else if (int'(line) == exp_line) begin
        rgbs[hpos] = {red, green, blue};
        blank_n += int'(blank);
        rgb_n += int'(red | green | blue);
        diff_n += int'(blank !== (red | green | blue));
        if (blank === 1'b1 && first_h < 0) begin
          first_h = int'(hpos);
        end
      end
      // third area line: row word index 2 inside screen row 0
      if (int'(line) == exp_line + 2 && hpos == 10'h064) begin
        row_info = int'({char_row, row_addr[3:0]});
      end
    end
  endtask : frame

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // ==========================================
  // tests
  initial begin
    enable = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    write = 1'b0;
    read = 1'b0;
    mode = 1'b0;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ORIGIN_ADDR, ORIGIN_RESET);
    wr(ORIGIN_ADDR, 8'ha5);
    rd(ORIGIN_ADDR, 8'ha5);
    wr(4'h2, 8'h3c);
    rd(ORIGIN_ADDR, 8'ha5);
    rd(4'h0, 8'h00);
    // plain rows, colours 1..7 in turn, two black cells among 19
    frame(4'h0, 4'h0, 1'b1, 1'b0);
    check(16'(pre_n), 16'h0000);
    check(16'(row_info), 16'h0002);
    check(16'(blank_n), 16'h01fe);
    check(16'(rgb_n), 16'h01fe);
    check(16'(diff_n), 16'h0000);
    check({15'h0000, first_h >= 94 && first_h <= 97}, 16'h0001);
    a_h = first_h;
    for (int k = 0; k < 7; k++) begin
      check({13'h0000, rgbs[first_h + 30 * k + 1]}, 16'(k + 1));
    end
    // trimmed first cell, line closed early by a carriage return
    frame(4'h3, 4'h5, 1'b1, 1'b1);
    check(16'(pre_n), 16'h0000);
    check(16'(row_info), 16'h0002);
    check(16'(first_h - a_h), 16'h000f);
    check(16'(blank_n), 16'h0066);
    check(16'(rgb_n), 16'h0060);
    check(16'(diff_n), 16'h0006);
    // display off keeps red, green, blue and blanking low
    frame(4'h0, 4'h0, 1'b0, 1'b0);
    check(16'(pre_n + blank_n + rgb_n), 16'h0000);
    results();
  end

  // a frame is 16800 cycles; three frames plus one wait fit well inside
  initial begin
    repeat (90000) @(posedge ref_clk);
    bad_count++;
    results();
  end
endmodule : tb_osd_output_and_origin
